// File: rtl/integer_add_params.svh
`ifndef INTEGER_ADD_PARAMS_SVH
`define INTEGER_ADD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------------
`define OFS_GPR_BASE  12'h000
`define OFS_GPR_END   12'h080
`define OFS_INSTR     12'h080
`define OFS_STATUS    12'h084
`define OFS_RESULT    12'h088
`define ADDR_ALIGN_MSB 1
`define ADDR_IDX_MSB   6
`define ADDR_IDX_LSB   2

// ----------------------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------------------
`define ST_CARRY_BIT   0
`define ST_ILLEGAL_BIT 1
`define CARRY_RST      1'b0
`define ILLEGAL_RST    1'b0
`define WORD_RST       32'h0000_0000

// ----------------------------------------------------------------------------
// Instruction fields, little-endian indices (bit 0 of the word is the LSB)
// ----------------------------------------------------------------------------
`define CLASS_MSB     31
`define CLASS_LSB     30
`define IMM_SEL_BIT   29
`define KEEP_BIT      28
`define CIN_BIT       27
`define OP_ZERO_BIT   26
`define RD_MSB        25
`define RD_LSB        21
`define RA_MSB        20
`define RA_LSB        16
`define RB_MSB        15
`define RB_LSB        11
`define IMM_MSB       15
`define IMM_LSB       0
`define ADD_CLASS     2'b00
`define IMM_W         16

`endif

// File: rtl/integer_add_pkg.sv
package integer_add_pkg;

    typedef logic [31:0] word_t;
    typedef logic [4:0]  gpr_idx_t;

    typedef enum logic [3:0] {
        VAR_PLAIN  = 4'b0001,
        VAR_KEEP   = 4'b0010,
        VAR_CARRY  = 4'b0100,
        VAR_KEEPC  = 4'b1000
    } add_variant_t;

endpackage

// File: rtl/add_exec_if.sv
`timescale 1ns/1ps

interface add_exec_if;
    integer_add_pkg::word_t        instr;
    logic                          fire;
    logic                          carry_flag;
    integer_add_pkg::word_t        opnd_a;
    integer_add_pkg::word_t        opnd_b_reg;
    integer_add_pkg::gpr_idx_t     rd_idx;
    integer_add_pkg::gpr_idx_t     ra_idx;
    integer_add_pkg::gpr_idx_t     rb_idx;
    integer_add_pkg::word_t        opnd_b;
    logic                          carry_in;
    integer_add_pkg::word_t        result;
    logic                          carry_out;
    logic                          wr_en;
    logic                          carry_we;
    logic                          illegal;
    integer_add_pkg::add_variant_t variant;

    modport exec (
        input  instr, fire, carry_flag, opnd_a, opnd_b_reg,
        output rd_idx, ra_idx, rb_idx, opnd_b, carry_in, result, carry_out,
        output wr_en, carry_we, illegal, variant
    );

    modport core (
        output instr, fire, carry_flag, opnd_a, opnd_b_reg,
        input  rd_idx, ra_idx, rb_idx, opnd_b, carry_in, result, carry_out,
        input  wr_en, carry_we, illegal, variant
    );
endinterface

// File: rtl/add_exec.sv
`timescale 1ns/1ps
`include "integer_add_params.svh"

module add_exec (
    add_exec_if.exec ex
);
    logic                   legal;
    logic                   keep_sel;
    logic                   cin_sel;
    logic [32:0]            sum_ext;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    always_comb
    begin
        legal     = (ex.instr[`CLASS_MSB:`CLASS_LSB] == `ADD_CLASS) && !ex.instr[`OP_ZERO_BIT];
        keep_sel  = ex.instr[`KEEP_BIT];
        cin_sel   = ex.instr[`CIN_BIT];
        ex.rd_idx = ex.instr[`RD_MSB:`RD_LSB];
        ex.ra_idx = ex.instr[`RA_MSB:`RA_LSB];
        ex.rb_idx = ex.instr[`RB_MSB:`RB_LSB];
        unique case ({keep_sel, cin_sel})
            2'b00:   ex.variant = integer_add_pkg::VAR_PLAIN;
            2'b10:   ex.variant = integer_add_pkg::VAR_KEEP;
            2'b01:   ex.variant = integer_add_pkg::VAR_CARRY;
            2'b11:   ex.variant = integer_add_pkg::VAR_KEEPC;
        endcase
    end

    // ------------------------------------------------------------------------
    // Adder
    // ------------------------------------------------------------------------
    always_comb
    begin
        // The selector bit only chooses whether the flag is used; the flag itself is separate.
        ex.carry_in = cin_sel ? ex.carry_flag : 1'b0;
        if (ex.instr[`IMM_SEL_BIT])
            ex.opnd_b = {{(32 - `IMM_W){ex.instr[`IMM_MSB]}}, ex.instr[`IMM_MSB:`IMM_LSB]};
        else
            ex.opnd_b = ex.opnd_b_reg;
        sum_ext      = {1'b0, ex.opnd_a} + {1'b0, ex.opnd_b} + {32'h0000_0000, ex.carry_in};
        ex.result    = sum_ext[31:0];
        ex.carry_out = sum_ext[32];
        ex.wr_en     = ex.fire && legal;
        ex.carry_we  = ex.fire && legal && !keep_sel;
        ex.illegal   = ex.fire && !legal;
    end
endmodule

// File: rtl/integer_add_unit.sv
// Functional notes
// - Register form places the opcode in bits 0-5, destination at bit 6, first source at 11, second at 16, bit 0 MSB.
// - Immediate form places destination at bit 6, source at bit 11 and a 16-bit literal in bits 16 to 31.
// - Register form writes the sum of both source registers to the destination.
// - Immediate form sign-extends the literal to 32 bits and adds it to the first source.
// - With instruction bit 3 set the status carry flag is left unchanged.
// - With instruction bit 3 clear the status carry flag takes the adder carry-out.
// - With instruction bit 4 set the status carry flag is added as carry-in.
// - With instruction bit 4 clear the carry-in is zero and the flag is ignored.
// - The keep variant sets only bit 3, the carry variant only bit 4, the combined one both.
// - The operand register file holds 32 general registers addressed by 5-bit fields.
`timescale 1ns/1ps
`include "integer_add_params.svh"

module integer_add_unit #(
    parameter int ADDR_W  = 12,
    parameter int NUM_GPR = 32
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   status_carry_flag,
    output logic                   gpr_wr_en
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    integer_add_pkg::word_t gpr_ff [NUM_GPR];
    integer_add_pkg::word_t nxt_gpr [NUM_GPR];
    logic                   carry_ff;
    logic                   nxt_carry;
    logic                   illegal_ff;
    logic                   nxt_illegal;
    integer_add_pkg::word_t result_ff;
    integer_add_pkg::word_t nxt_result;
    integer_add_pkg::word_t prdata_ff;
    integer_add_pkg::word_t nxt_prdata;
    logic                   wr_en_ff;
    logic                   nxt_wr_en;

    logic                   setup_ph;
    logic                   wr_acc;
    logic                   aligned;
    logic                   gpr_hit;
    logic                   instr_hit;
    logic                   status_hit;
    logic                   result_hit;
    logic                   mapped;
    logic                   exec_fire;
    logic [4:0]             gpr_sel;

    add_exec_if ex_if ();

    add_exec u_exec (
        .ex (ex_if.exec)
    );

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    always_comb
    begin
        setup_ph   = psel && !penable;
        wr_acc     = psel && penable && pwrite;
        aligned    = (paddr[`ADDR_ALIGN_MSB:0] == 2'b00);
        gpr_hit    = aligned && (paddr < ADDR_W'(`OFS_GPR_END));
        instr_hit  = (paddr == ADDR_W'(`OFS_INSTR));
        status_hit = (paddr == ADDR_W'(`OFS_STATUS));
        result_hit = (paddr == ADDR_W'(`OFS_RESULT));
        mapped     = gpr_hit || instr_hit || status_hit || result_hit;
        gpr_sel    = paddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
        exec_fire  = wr_acc && instr_hit;
        // The unit never stalls, so every access completes in its first access cycle.
        pready     = 1'b1;
        pslverr    = psel && penable && !mapped;
    end

    always_comb
    begin
        ex_if.instr      = pwdata;
        ex_if.fire       = exec_fire;
        ex_if.carry_flag = carry_ff;
        ex_if.opnd_a     = gpr_ff[ex_if.ra_idx];
        ex_if.opnd_b_reg = gpr_ff[ex_if.rb_idx];
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        nxt_carry = carry_ff;
        if (wr_acc && status_hit)
            nxt_carry = pwdata[`ST_CARRY_BIT];
        if (ex_if.carry_we)
            nxt_carry = ex_if.carry_out;
        // The sticky error bit is write-one-to-clear; a new error in the same cycle wins.
        nxt_illegal = illegal_ff;
        if (wr_acc && status_hit && pwdata[`ST_ILLEGAL_BIT])
            nxt_illegal = 1'b0;
        if (ex_if.illegal)
            nxt_illegal = 1'b1;
        nxt_result = ex_if.wr_en ? ex_if.result : result_ff;
        nxt_wr_en  = ex_if.wr_en;
        nxt_prdata = prdata_ff;
        if (setup_ph)
        begin
            nxt_prdata = `WORD_RST;
            if (gpr_hit)
                nxt_prdata = gpr_ff[gpr_sel];
            else if (status_hit)
            begin
                nxt_prdata[`ST_CARRY_BIT]   = carry_ff;
                nxt_prdata[`ST_ILLEGAL_BIT] = illegal_ff;
            end
            else if (result_hit)
                nxt_prdata = result_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------------
    // A bus write and an executing add both need the one access phase, so they never meet in a cycle.
    for (genvar g = 0; g < NUM_GPR; g++)
    begin : g_gpr
        always_comb
        begin
            nxt_gpr[g] = gpr_ff[g];
            if (wr_acc && gpr_hit && (gpr_sel == 5'(g)))
                nxt_gpr[g] = pwdata;
            if (ex_if.wr_en && (ex_if.rd_idx == 5'(g)))
                nxt_gpr[g] = ex_if.result;
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                gpr_ff[g] <= `WORD_RST;
            else
                gpr_ff[g] <= nxt_gpr[g];
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            carry_ff   <= `CARRY_RST;
            illegal_ff <= `ILLEGAL_RST;
            result_ff  <= `WORD_RST;
            prdata_ff  <= `WORD_RST;
            wr_en_ff   <= 1'b0;
        end
        else
        begin
            carry_ff   <= nxt_carry;
            illegal_ff <= nxt_illegal;
            result_ff  <= nxt_result;
            prdata_ff  <= nxt_prdata;
            wr_en_ff   <= nxt_wr_en;
        end
    end

    always_comb
    begin
        prdata            = prdata_ff;
        status_carry_flag = carry_ff;
        gpr_wr_en         = wr_en_ff;
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic legal_fire;
    assign legal_fire = ex_if.wr_en;

    a_field_place: assert property (
        exec_fire |-> (ex_if.rd_idx == pwdata[25:21]) && (ex_if.ra_idx == pwdata[20:16])
                      && (ex_if.rb_idx == pwdata[15:11]))
        else $error("register fields decoded from wrong bit positions");

    a_imm_literal: assert property (
        (exec_fire && pwdata[`IMM_SEL_BIT]) |-> (ex_if.opnd_b[15:0] == pwdata[15:0]))
        else $error("immediate literal not taken from the low half-word");

    a_rr_sum: assert property (
        (legal_fire && !pwdata[`IMM_SEL_BIT]) |=>
            gpr_ff[$past(ex_if.rd_idx)] == $past(ex_if.opnd_a) + $past(ex_if.opnd_b_reg)
                                           + {31'h0000_0000, $past(pwdata[`CIN_BIT] && carry_ff)})
        else $error("register-form sum not committed");

    a_imm_sext: assert property (
        (exec_fire && pwdata[`IMM_SEL_BIT]) |-> (ex_if.opnd_b[31:16] == {16{pwdata[15]}}))
        else $error("immediate not sign-extended");

    a_keep_carry: assert property (
        (exec_fire && pwdata[`KEEP_BIT]) |=> $stable(carry_ff))
        else $error("carry flag changed under keep");

    a_load_carry: assert property (
        (legal_fire && !pwdata[`KEEP_BIT]) |=> (carry_ff == $past(ex_if.carry_out)))
        else $error("carry flag not loaded with carry-out");

    a_carry_in_use: assert property (
        (exec_fire && pwdata[`CIN_BIT]) |-> (ex_if.carry_in == carry_ff))
        else $error("carry flag not used as carry-in");

    a_carry_in_zero: assert property (
        (exec_fire && !pwdata[`CIN_BIT]) |-> !ex_if.carry_in)
        else $error("carry-in not zero");

    a_variant_map: assert property (
        exec_fire |-> ((ex_if.variant == integer_add_pkg::VAR_KEEPC) == (pwdata[28] && pwdata[27]))
                      && ((ex_if.variant == integer_add_pkg::VAR_KEEP) == (pwdata[28] && !pwdata[27]))
                      && ((ex_if.variant == integer_add_pkg::VAR_CARRY) == (!pwdata[28] && pwdata[27])))
        else $error("variant decode mismatch");

    a_one_cycle: assert property (
        legal_fire |-> pready ##1 (gpr_wr_en && (gpr_ff[$past(ex_if.rd_idx)] == $past(ex_if.result)))
                          ##1 !gpr_wr_en)
        else $error("commit not completed in one cycle");

    a_wren_cause: assert property (
        gpr_wr_en |-> $past(legal_fire))
        else $error("write enable without an instruction");

    a_gpr_bus_write: assert property (
        (wr_acc && gpr_hit) |=> (gpr_ff[$past(gpr_sel)] == $past(pwdata)))
        else $error("register file write over the bus lost");

    a_gpr_readback: assert property (
        (setup_ph && gpr_hit) |=> (prdata == $past(gpr_ff[gpr_sel])))
        else $error("register file read returned wrong word");

    a_status_read: assert property (
        (setup_ph && status_hit) |=> (prdata[`ST_CARRY_BIT] == $past(carry_ff))
                                     && (prdata[`ST_ILLEGAL_BIT] == $past(illegal_ff)))
        else $error("status read does not show the flags");

    a_status_write: assert property (
        (wr_acc && status_hit) |=> (carry_ff == $past(pwdata[`ST_CARRY_BIT])))
        else $error("carry flag not written over the bus");

    a_misalign_err: assert property (
        (psel && penable && (paddr[`ADDR_ALIGN_MSB:0] != 2'b00)) |-> pslverr)
        else $error("misaligned access not refused");

    a_unmapped_read: assert property (
        (setup_ph && !mapped) |=> (prdata == `WORD_RST))
        else $error("unmapped read not zero");

    a_instr_reads_zero: assert property (
        (setup_ph && instr_hit) |=> (prdata == `WORD_RST))
        else $error("instruction port read not zero");

    a_no_wait: assert property (
        (psel && penable) |-> pready)
        else $error("access phase stalled");

    a_illegal_sticky: assert property (
        ex_if.illegal |=> illegal_ff)
        else $error("illegal opcode not recorded");

    a_illegal_quiet: assert property (
        ex_if.illegal |=> !gpr_wr_en && $stable(carry_ff))
        else $error("illegal opcode changed state");

    a_illegal_clear: assert property (
        (wr_acc && status_hit && pwdata[`ST_ILLEGAL_BIT]) |=> !illegal_ff)
        else $error("illegal flag not cleared by write of one");

    a_result_latch: assert property (
        legal_fire |=> (result_ff == $past(ex_if.result)))
        else $error("last result not captured");

    a_carry_hold: assert property (
        (!ex_if.carry_we && !(wr_acc && status_hit)) |=> $stable(carry_ff))
        else $error("carry flag changed with no cause");

    a_wren_pulse: assert property (
        gpr_wr_en |=> !gpr_wr_en)
        else $error("write enable longer than one cycle");

    a_reset_quiet: assert property (
        $rose(presetn) |-> !carry_ff && !gpr_wr_en)
        else $error("carry or write enable set after reset");

    c_add_plain: cover property (legal_fire && ex_if.variant == integer_add_pkg::VAR_PLAIN ##1 carry_ff);
    c_addi_carry: cover property (legal_fire && pwdata[`IMM_SEL_BIT] && ex_if.carry_in);
    c_keepc: cover property (legal_fire && ex_if.variant == integer_add_pkg::VAR_KEEPC);
    c_illegal: cover property (ex_if.illegal ##1 illegal_ff);
    c_keep_imm: cover property (legal_fire && pwdata[`IMM_SEL_BIT] && pwdata[`KEEP_BIT]);
endmodule

// File: bench/apb_master.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Bus master standing in for the core that feeds the adder
// ----------------------------------------------------------------------------
module apb_master (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // Called just after a rising edge; leaves one idle cycle so no signal is driven twice in a step.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// File: bench/tb_integer_add_unit.sv
`timescale 1ns/1ps
`include "integer_add_params.svh"

module tb_integer_add_unit;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        status_carry_flag;
    logic        gpr_wr_en;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          pulses = 0;
    logic [31:0] m [32];
    logic        mc;

    integer_add_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .status_carry_flag(status_carry_flag), .gpr_wr_en(gpr_wr_en));
    apb_master u_mst (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Counting pulses lets a stretched or doubled write enable show up.
    always @(posedge pclk)
        if (gpr_wr_en === 1'b1)
            pulses++;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        u_mst.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] q;
        logic        e;
        u_mst.xfer(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask

    function automatic logic [31:0] mk(input logic i, input logic k, input logic c,
                                       input logic [4:0] d, input logic [4:0] a, input logic [15:0] lo);
        return {2'b00, i, k, c, 1'b0, d, a, lo};
    endfunction

    task automatic set_carry(input logic c);
        wr(`OFS_STATUS, {31'h0, c});
        mc = c;
    endtask

    // Works out the sum from the mirror, then runs the instruction and checks the carry flag, the destination register and the write-enable pulse count.
    task automatic exe(input logic [31:0] ins);
        logic [31:0] b;
        logic [32:0] s;
        b = ins[29] ? {{16{ins[15]}}, ins[15:0]} : m[ins[15:11]];
        s = {1'b0, m[ins[20:16]]} + {1'b0, b} + {32'h0, ins[27] & mc};
        pulses = 0;
        wr(`OFS_INSTR, ins);
        m[ins[25:21]] = s[31:0];
        if (!ins[28])
            mc = s[32];
        chk({31'h0, status_carry_flag}, {31'h0, mc});
        rdc({5'h0, ins[25:21], 2'b00}, m[ins[25:21]], 1'b0);
        chk(32'(pulses), 32'h1);
    endtask

    task automatic print_verdict();
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        logic [31:0] r;
        logic [31:0] x;
        presetn = 1'b0;
        mc = 1'b0;
        void'($urandom(32'h1d6c96af));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, status_carry_flag}, 32'h0);
        chk({31'h0, gpr_wr_en}, 32'h0);
        rdc(`OFS_STATUS, 32'h0, 1'b0);
        rdc(12'h014, 32'h0, 1'b0);
        for (int i = 0; i < 32; i++)
        begin
            m[i] = $urandom;
            wr(12'(i * 4), m[i]);
        end
        m[1] = 32'hffff_ffff;
        m[2] = 32'h0000_0001;
        wr(12'h004, m[1]);
        wr(12'h008, m[2]);
        for (int i = 0; i < 32; i++)
            rdc(12'(i * 4), m[i], 1'b0);
        // Corners: carry-out at the top of the range, carry-in with keep, negative literals.
        set_carry(1'b1);
        exe(mk(1'b0, 1'b0, 1'b0, 5'd3, 5'd1, {5'd2, 11'h0}));
        exe(mk(1'b0, 1'b1, 1'b1, 5'd4, 5'd1, {5'd2, 11'h0}));
        exe(mk(1'b1, 1'b0, 1'b1, 5'd5, 5'd2, 16'hffff));
        exe(mk(1'b1, 1'b1, 1'b0, 5'd6, 5'd1, 16'h8000));
        set_carry(1'b0);
        exe(mk(1'b0, 1'b0, 1'b1, 5'd31, 5'd31, {5'd1, 11'h0}));
        for (int i = 0; i < 48; i++)
        begin
            r = $urandom;
            x = $urandom;
            set_carry(r[31]);
            exe(mk(r[0], r[1], r[2], r[7:3], r[12:8], r[0] ? x[15:0] : {x[4:0], 11'h0}));
        end
        // Unmapped and misaligned places answer with an error and read zero.
        rdc(12'h08c, 32'h0, 1'b1);
        rdc(12'h002, 32'h0, 1'b1);
        // An opcode outside the add class must leave registers and carry alone.
        pulses = 0;
        wr(`OFS_INSTR, {2'b01, 30'h3fff_ffff});
        chk(32'(pulses), 32'h0);
        chk({31'h0, status_carry_flag}, {31'h0, mc});
        rdc(`OFS_STATUS, {30'h0, 1'b1, mc}, 1'b0);
        wr(`OFS_STATUS, {30'h0, 1'b1, mc});
        rdc(`OFS_STATUS, {31'h0, mc}, 1'b0);
        // A reset in mid-run must drop a set carry flag and clear the register file.
        set_carry(1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0, status_carry_flag}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({31'h0, gpr_wr_en}, 32'h0);
        rdc(`OFS_STATUS, 32'h0, 1'b0);
        rdc(12'h00c, 32'h0, 1'b0);
        print_verdict();
    end

    initial
    begin
        #100000;
        error_cnt++;
        print_verdict();
    end
endmodule
